// ===== pll_status_event_defines.svh
// offsets, field positions, reset values and timing counts
// included by the loop status register bank and by its testbench
`ifndef PLL_STATUS_EVENT_DEFINES_SVH
`define PLL_STATUS_EVENT_DEFINES_SVH
// register byte addresses
`define ADR_DELAY    8'h00
`define ADR_STATUS   8'h04
`define ADR_EVENT    8'h08
`define ADR_LOLCNT   8'h0C
`define ADR_LOCKCFG  8'h10
`define ADR_IRQMASK  8'h14
`define ADR_IRQSTS   8'h18
// reset values
`define DELAY_RST    8'h1F
`define LOCK_IVL_RST 16'h00FF
`define LOCK_THR_RST 16'h0155
// alarm threshold of the loss-of-lock counter
`define LOL_THRESH   4'h7
// event bit positions
`define EV_STATE     3
`define EV_HOLD      2
`define EV_LIMIT     1
`define EV_LOL       0
// status bit positions
`define ST_LOCK      0
`define ST_REF       1
`define ST_STATE     4
// lock interval unit
`define CLK_MHZ      100
`define LOCK_UNIT_MS 1
`define MS_CYCLES    (`LOCK_UNIT_MS * `CLK_MHZ * 1000)
`endif

// ===== pll_status_event_pkg.sv
// types shared by the loop status register bank
// no assumptions beyond a SystemVerilog tool
package pll_status_event_pkg;
    // loop state, order gives the reported code
    typedef enum logic [2:0] {
        S_FREERUN, S_NORMAL, S_HOLDOVER,
        S_WRFREQ, S_ACQUIRE, S_HITLESS
    } loop_state_t;
    // controls coming from the rest of the loop
    typedef struct packed {
        logic ref_ok;
        logic wr_freq;
        logic hitless;
        logic ref_sel;
    } loop_ctrl_t;
    // one bit per event, msb is bit 3
    typedef struct packed {
        logic state_ch;
        logic holdover;
        logic limit;
        logic lol;
    } event_t;
endpackage : pll_status_event_pkg

// ===== pll_status_event_regs.sv
// loop status, sticky events and loss-of-lock counter
// assumes a classic wishbone master on MCLK and loop
// controls synchronous to MCLK
//
// Operation
// - debug converter delay, 8 bits, resets 0x1F
// - status bits 6:4 report loop state
// - status bit 1 reports selected reference
// - status bit 0 reports present lock
// - event bit 3 set on state change
// - event bit 2 set entering holdover
// - event bits cleared by writing one
// - event bit 1 set while count exceeds threshold
// - alarm bit uncleareable while count exceeds threshold
// - event bit 0 set on lock loss
// - counter counts lock losses, saturates 0xF
// - writing zero clears counter, counting restarts
// - writing counter presets it to value
// - counter writes ignored when gated or reset
// - lock after error below threshold for interval, relock in normal after half interval
// - acquire to normal at half interval
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pll_status_event_defines.svh"

module pll_status_event_regs
    import pll_status_event_pkg::*;
#(
    parameter int ERR_W     = 17,
    parameter int MS_CYCLES = `MS_CYCLES
) (
    // clock and reset
    input  wire logic             MCLK,
    input  wire logic             RST,
    // wishbone slave
    input  wire logic             WB_CYC_I,
    input  wire logic             WB_STB_I,
    input  wire logic             WB_WE_I,
    input  wire logic [7:0]       WB_ADR_I,
    input  wire logic [3:0]       WB_SEL_I,
    input  wire logic [31:0]      WB_DAT_I,
    output logic      [31:0]      WB_DAT_O,
    output logic                  WB_ACK_O,
    // loop side
    input  wire loop_ctrl_t       LOOP_CTRL,
    input  wire logic [ERR_W-1:0] PHASE_ERR,
    input  wire logic             LOOP_SOFT_RESET,
    input  wire logic             CLOCK_GATED,
    // outputs to the loop and the system
    output logic      [7:0]       CONVERTER_DELAY,
    output logic      [2:0]       LOOP_STATE,
    output logic                  LOCKED,
    output logic                  IRQ
);
    // ************************************************
    // helper functions
    // ************************************************
    // magnitude of the signed phase error
    function automatic logic [ERR_W-1:0] mag(
        input logic [ERR_W-1:0] v);
        mag = v[ERR_W-1] ? (~v + 1'b1) : v;
    endfunction : mag
    // saturating increment of the lock loss count
    function automatic logic [3:0] sat_inc(
        input logic [3:0] v, input logic inc);
        sat_inc = (inc && v != 4'hF) ? v + 4'h1 : v;
    endfunction : sat_inc
    // ************************************************
    // bus decode
    // ************************************************
    logic        ack_reg;
    logic        req;
    logic        wr;
    logic        rd;
    logic        sreset;
    logic        blocked;
    logic        wr_ev;
    logic        wr_cnt;
    logic        wr_cnt_ok;
    // one access per request, ack drops after one cycle
    assign req       = WB_CYC_I & WB_STB_I & ~ack_reg;
    assign wr        = req & WB_WE_I;
    assign rd        = req & ~WB_WE_I;
    assign sreset    = LOOP_SOFT_RESET;
    assign blocked   = LOOP_SOFT_RESET | CLOCK_GATED;
    assign wr_ev     = wr & WB_SEL_I[0] & (WB_ADR_I == `ADR_EVENT);
    assign wr_cnt    = wr & WB_SEL_I[0] & (WB_ADR_I == `ADR_LOLCNT);
    assign wr_cnt_ok = wr_cnt & ~blocked;
    assign WB_ACK_O  = ack_reg;
    // acknowledge every access, mapped or not
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end
    // ************************************************
    // configuration registers
    // ************************************************
    logic [7:0]  delay_reg;
    logic [15:0] ivl_reg;
    logic [15:0] thr_reg;
    logic [3:0]  mask_reg;
    // debug delay, lock setup and interrupt mask
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            delay_reg <= `DELAY_RST;
            ivl_reg   <= `LOCK_IVL_RST;
            thr_reg   <= `LOCK_THR_RST;
            mask_reg  <= 4'h0;
        end else if (wr) begin
            if (WB_ADR_I == `ADR_DELAY && WB_SEL_I[0]) begin
                delay_reg <= WB_DAT_I[7:0];
            end
            if (WB_ADR_I == `ADR_LOCKCFG) begin
                if (WB_SEL_I[0]) thr_reg[7:0]  <= WB_DAT_I[7:0];
                if (WB_SEL_I[1]) thr_reg[15:8] <= WB_DAT_I[15:8];
                if (WB_SEL_I[2]) ivl_reg[7:0]  <= WB_DAT_I[23:16];
                if (WB_SEL_I[3]) ivl_reg[15:8] <= WB_DAT_I[31:24];
            end
            if (WB_ADR_I == `ADR_IRQMASK && WB_SEL_I[0]) begin
                mask_reg <= WB_DAT_I[3:0];
            end
        end
    end
    assign CONVERTER_DELAY = delay_reg;
    // ************************************************
    // lock timing
    // ************************************************
    logic [31:0] tick_cnt_reg;
    logic        tick;
    logic [15:0] met_ms_reg;
    logic [15:0] half_ivl;
    logic        met;
    logic        half_met;
    loop_state_t state_reg;
    loop_state_t state_next;
    assign tick     = (tick_cnt_reg == 32'(MS_CYCLES - 1));
    assign met      = mag(PHASE_ERR) < ERR_W'(thr_reg);
    assign half_ivl = {1'b0, ivl_reg[15:1]} + {15'h0, ivl_reg[0]};
    assign half_met = met && (met_ms_reg >= half_ivl);
    // millisecond tick
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            tick_cnt_reg <= 32'h0;
        end else if (tick) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end
    // time the error has stayed below threshold
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            met_ms_reg <= 16'h0;
        end else if (sreset || !met || state_next != state_reg) begin
            met_ms_reg <= 16'h0;
        end else if (tick && met_ms_reg != 16'hFFFF) begin
            met_ms_reg <= met_ms_reg + 16'h1;
        end
    end
    // ************************************************
    // loop state machine
    // ************************************************
    // next loop state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_FREERUN: begin
                if (LOOP_CTRL.ref_ok) state_next = S_ACQUIRE;
            end
            S_ACQUIRE: begin
                if (!LOOP_CTRL.ref_ok) state_next = S_HOLDOVER;
                else if (half_met) state_next = S_NORMAL;
            end
            S_NORMAL: begin
                if (!LOOP_CTRL.ref_ok) state_next = S_HOLDOVER;
                else if (LOOP_CTRL.hitless) state_next = S_HITLESS;
            end
            S_HITLESS: begin
                if (!LOOP_CTRL.ref_ok) state_next = S_HOLDOVER;
                else if (!LOOP_CTRL.hitless) state_next = S_NORMAL;
            end
            S_HOLDOVER: begin
                if (LOOP_CTRL.ref_ok) state_next = S_ACQUIRE;
            end
            S_WRFREQ: begin
                if (!LOOP_CTRL.wr_freq) state_next = S_FREERUN;
            end
            default: begin
                state_next = S_FREERUN;
            end
        endcase
        if (LOOP_CTRL.wr_freq) state_next = S_WRFREQ;
    end
    // state register, soft reset returns to free-run
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_reg <= S_FREERUN;
        end else if (sreset) begin
            state_reg <= S_FREERUN;
        end else begin
            state_reg <= state_next;
        end
    end
    // ************************************************
    // lock and reference status
    // ************************************************
    logic lock_reg;
    logic lock_next;
    logic ref_reg;
    logic lol_fall;
    // lock needs a second half interval in normal
    always_comb begin
        lock_next = lock_reg;
        if (state_next != S_NORMAL && state_next != S_HITLESS) begin
            lock_next = 1'b0;
        end else if (!met) begin
            lock_next = 1'b0;
        end else if (state_reg == S_NORMAL && half_met) begin
            lock_next = 1'b1;
        end
    end
    assign lol_fall = lock_reg & ~lock_next & ~sreset;
    // present lock and selected reference
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            lock_reg <= 1'b0;
            ref_reg  <= 1'b0;
        end else if (sreset) begin
            lock_reg <= 1'b0;
            ref_reg  <= 1'b0;
        end else begin
            lock_reg <= lock_next;
            ref_reg  <= LOOP_CTRL.ref_sel;
        end
    end
    assign LOOP_STATE = state_reg;
    assign LOCKED     = lock_reg;
    // ************************************************
    // loss-of-lock counter and events
    // ************************************************
    logic [3:0] cnt_reg;
    logic [3:0] cnt_base;
    logic       over;
    logic       over_reg;
    event_t     ev_reg;
    event_t     ev_set;
    event_t     ev_clr;
    // fixed threshold compared every cycle
    assign over = cnt_reg > `LOL_THRESH;
    // a write presets, a coincident loss still counts
    assign cnt_base = wr_cnt_ok ? WB_DAT_I[3:0] : cnt_reg;
    // counter with saturation
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cnt_reg <= 4'h0;
        end else if (sreset) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= sat_inc(cnt_base, lol_fall);
        end
    end
    // event causes
    always_comb begin
        ev_set.state_ch = (state_next != state_reg);
        ev_set.holdover = (state_next == S_HOLDOVER)
                        && (state_reg != S_HOLDOVER);
        ev_set.limit    = over;
        ev_set.lol      = lol_fall;
        ev_clr          = wr_ev ? event_t'(WB_DAT_I[3:0]) : 4'h0;
        ev_clr.limit    = ev_clr.limit & ~over;
    end
    // sticky events, a set wins over a clear
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ev_reg <= 4'h0;
        end else if (sreset) begin
            ev_reg <= 4'h0;
        end else begin
            ev_reg <= (ev_reg & ~ev_clr) | ev_set;
        end
    end
    // ************************************************
    // interrupt status
    // ************************************************
    logic [3:0] irq_reg;
    logic [3:0] irq_set;
    logic       rd_irq;
    assign irq_set = {ev_set.state_ch, ev_set.holdover,
                      over & ~over_reg, ev_set.lol};
    assign rd_irq  = rd & (WB_ADR_I == `ADR_IRQSTS);
    assign IRQ     = |(irq_reg & mask_reg);
    // read clears, new events win
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            irq_reg  <= 4'h0;
            over_reg <= 1'b0;
        end else begin
            irq_reg  <= (rd_irq ? 4'h0 : irq_reg) | irq_set;
            over_reg <= over;
        end
    end
    // ************************************************
    // read data
    // ************************************************
    logic [31:0] rdata;
    // read mux, unmapped reads as zero
    always_comb begin
        rdata = 32'h0;
        case (WB_ADR_I)
            `ADR_DELAY:   rdata[7:0] = delay_reg;
            `ADR_STATUS: begin
                rdata[`ST_STATE+:3] = state_reg;
                rdata[`ST_REF]      = ref_reg;
                rdata[`ST_LOCK]     = lock_reg;
            end
            `ADR_EVENT:   rdata[3:0] = ev_reg;
            `ADR_LOLCNT:  rdata[3:0] = cnt_reg;
            `ADR_LOCKCFG: rdata = {ivl_reg, thr_reg};
            `ADR_IRQMASK: rdata[3:0] = mask_reg;
            `ADR_IRQSTS:  rdata[3:0] = irq_reg;
            default:      rdata = 32'h0;
        endcase
    end
    // read data held from the ack cycle on
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            WB_DAT_O <= 32'h0;
        end else if (rd) begin
            WB_DAT_O <= rdata;
        end
    end
    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    a_delay_write: assert property (
        wr && WB_SEL_I[0] && WB_ADR_I == `ADR_DELAY
        |=> CONVERTER_DELAY == $past(WB_DAT_I[7:0]))
        else $error("delay write lost");
    a_status_read: assert property (
        rd && WB_ADR_I == `ADR_STATUS
        |=> WB_ACK_O && WB_DAT_O[6:4] == $past(state_reg)
            && WB_DAT_O[1] == $past(ref_reg)
            && WB_DAT_O[0] == $past(LOCKED))
        else $error("status read wrong");
    a_state_event: assert property (
        $changed(state_reg) && !$past(sreset)
        |-> ev_reg.state_ch)
        else $error("state change not flagged");
    a_hold_event: assert property (
        state_reg == S_HOLDOVER && $past(state_reg) != S_HOLDOVER
        && !$past(sreset) |-> ev_reg.holdover)
        else $error("holdover not flagged");
    a_event_sticky: assert property (
        ev_reg.lol && !wr_ev && !sreset |=> ev_reg.lol)
        else $error("event lost without clear");
    a_limit_hold: assert property (
        over && !sreset |=> ev_reg.limit)
        else $error("alarm bit clear while over");
    a_lol_event: assert property (
        $fell(lock_reg) && !$past(sreset)
        |-> ev_reg.lol && cnt_reg != 4'h0)
        else $error("lock loss not recorded");
    a_cnt_sat: assert property (
        cnt_reg == 4'hF && !sreset && !wr_cnt
        |=> cnt_reg == 4'hF)
        else $error("counter wrapped");
    a_cnt_preset: assert property (
        wr_cnt_ok && !lol_fall
        |=> cnt_reg == $past(WB_DAT_I[3:0]))
        else $error("counter preset lost");
    a_cnt_blocked: assert property (
        wr_cnt && CLOCK_GATED && !sreset && !lol_fall
        |=> $stable(cnt_reg))
        else $error("gated write changed counter");
    a_acq_normal: assert property (
        state_reg == S_ACQUIRE && LOOP_CTRL.ref_ok
        && !LOOP_CTRL.wr_freq && half_met && !sreset
        |=> state_reg == S_NORMAL)
        else $error("acquire did not advance");
    a_soft_reset: assert property (
        sreset |=> ev_reg == 4'h0 && cnt_reg == 4'h0
        && state_reg == S_FREERUN && !lock_reg)
        else $error("soft reset left state");

    c_lock_gain: cover property ($rose(lock_reg));
    c_lol_alarm: cover property ($rose(over));
    c_ev_clear:  cover property (wr_ev ##1 ev_reg == 4'h0);

endmodule : pll_status_event_regs

// ===== test_pll_status_event_regs.sv
// self-checking bench for the loop status register bank
// drives wishbone and loop controls itself, no partner model
`timescale 1ns/1ps
`include "pll_status_event_defines.svh"

module test_pll_status_event_regs
    import pll_status_event_pkg::*;
;
    // ****************************************
    // signals and instance
    // ****************************************
    logic              mclk  = 1'b0;
    logic              rst   = 1'b1;
    logic              cyc   = 1'b0;
    logic              stb   = 1'b0;
    logic              we    = 1'b0;
    logic [7:0]        adr   = 8'h00;
    logic [3:0]        sel   = 4'h0;
    logic [31:0]       dati  = 32'h0;
    logic [31:0]       dato;
    logic              ack;
    loop_ctrl_t        ctrl  = '0;
    logic [16:0]       err   = 17'h00000;
    logic              srst  = 1'b0;
    logic              gated = 1'b0;
    logic [7:0]        delay;
    logic [2:0]        state;
    logic              locked;
    logic              irq;
    int                error_cnt = 0;
    int                n_tests   = 0;
    logic [31:0]       q;

    pll_status_event_regs #(.MS_CYCLES(10)) pll_status_event_regs_inst (
        .MCLK(mclk), .RST(rst),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack),
        .LOOP_CTRL(ctrl), .PHASE_ERR(err), .LOOP_SOFT_RESET(srst),
        .CLOCK_GATED(gated), .CONVERTER_DELAY(delay), .LOOP_STATE(state),
        .LOCKED(locked), .IRQ(irq)
    );

    // 100 MHz clock
    always #5 mclk = ~mclk;

    // ****************************************
    // tasks
    // ****************************************
    // compare and count
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        dati <= d;
        sel  <= 4'hF;
        // this wait ends when ack is seen, or by the watchdog if it never comes
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        r = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask : wr

    // read, mask and compare
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string nm);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        check(nm, r & m, e);
    endtask : rd

    // wait bounded for a lock level
    task automatic wait_lock(input logic v);
        int i;
        for (i = 0; i < 600 && locked !== v; i++) @(negedge mclk);
        check("locked", locked, v);
    endtask : wait_lock

    task automatic set_err(input logic [16:0] e, input logic v);
        @(posedge mclk);
        err <= e;
        wait_lock(v);
    endtask : set_err

    task automatic print_verdict();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // tests
    // ****************************************
    // watchdog against a hang
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        int n;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        // reset values and unmapped place
        rd(`ADR_DELAY, 32'hFFFFFFFF, 32'h1F, "delay rst");
        check("delay port", delay, 8'h1F);
        rd(`ADR_STATUS, 32'hFFFFFFFF, 32'h0, "status rst");
        rd(`ADR_EVENT, 32'hFFFFFFFF, 32'h0, "event rst");
        rd(`ADR_LOLCNT, 32'hFFFFFFFF, 32'h0, "count rst");
        rd(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
        wr(`ADR_DELAY, 32'hA5);
        rd(`ADR_DELAY, 32'hFFFFFFFF, 32'hA5, "delay rw");
        check("delay port", delay, 8'hA5);
        wr(`ADR_LOCKCFG, {16'h0004, 16'h0155});
        wb(1'b0, `ADR_IRQSTS, 32'h0, q);
        // reference qualifies: acquire then normal then lock
        @(posedge mclk);
        ctrl.ref_ok <= 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        check("acquire", state, 3'h4);
        rd(`ADR_EVENT, 32'hFFFFFFFF, 32'h08, "state ev");
        for (n = 0; n < 600 && state !== 3'h1; n++) @(negedge mclk);
        check("normal", state, 3'h1);
        check("no early lock", locked, 1'b0);
        for (n = 0; n < 600 && locked !== 1'b1; n++) @(negedge mclk);
        check("lock delay", n > 10 && n <= 22, 1'b1);
        rd(`ADR_STATUS, 32'hFFFFFFFF, 32'h11, "locked sts");
        // write one clears, write zero keeps
        wr(`ADR_EVENT, 32'h0);
        rd(`ADR_EVENT, 32'h08, 32'h08, "w0 keep");
        wr(`ADR_EVENT, 32'h08);
        rd(`ADR_EVENT, 32'h08, 32'h0, "w1 clear");
        @(posedge mclk);
        ctrl.ref_sel <= 1'b1;
        rd(`ADR_STATUS, 32'h03, 32'h03, "ref sel");
        // hitless switch and back, lock kept
        @(posedge mclk);
        ctrl.hitless <= 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        check("hitless", state, 3'h5);
        @(posedge mclk);
        ctrl.hitless <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        check("hitless end", state, 3'h1);
        check("lock kept", locked, 1'b1);
        // lock loss with interrupt unmasked
        wb(1'b0, `ADR_IRQSTS, 32'h0, q);
        wr(`ADR_IRQMASK, 32'h1);
        check("irq idle", irq, 1'b0);
        set_err(17'h00200, 1'b0);
        rd(`ADR_EVENT, 32'h01, 32'h01, "lol ev");
        rd(`ADR_STATUS, 32'h01, 32'h0, "unlock sts");
        rd(`ADR_LOLCNT, 32'hFFFFFFFF, 32'h1, "count inc");
        check("irq set", irq, 1'b1);
        rd(`ADR_IRQSTS, 32'h01, 32'h01, "irq sts");
        @(negedge mclk);
        check("irq clr", irq, 1'b0);
        wr(`ADR_IRQMASK, 32'h0);
        set_err(17'h00000, 1'b1);
        wr(`ADR_EVENT, 32'h0F);
        // fixed alarm threshold, not clearable while over
        wr(`ADR_LOLCNT, 32'h8);
        rd(`ADR_LOLCNT, 32'hFFFFFFFF, 32'h8, "preset");
        rd(`ADR_EVENT, 32'h02, 32'h02, "alarm set");
        wr(`ADR_EVENT, 32'h02);
        rd(`ADR_EVENT, 32'h02, 32'h02, "alarm held");
        wr(`ADR_LOLCNT, 32'h7);
        wr(`ADR_EVENT, 32'h02);
        rd(`ADR_EVENT, 32'h02, 32'h0, "alarm clr");
        // saturation, then clear and restart
        wr(`ADR_LOLCNT, 32'hF);
        set_err(17'h00200, 1'b0);
        check("irq masked", irq, 1'b0);
        rd(`ADR_LOLCNT, 32'hFFFFFFFF, 32'hF, "saturate");
        set_err(17'h00000, 1'b1);
        wr(`ADR_LOLCNT, 32'h0);
        rd(`ADR_LOLCNT, 32'hFFFFFFFF, 32'h0, "clear");
        set_err(17'h00200, 1'b0);
        rd(`ADR_LOLCNT, 32'hFFFFFFFF, 32'h1, "restart");
        set_err(17'h00000, 1'b1);
        // holdover entry
        wr(`ADR_EVENT, 32'h0F);
        @(posedge mclk);
        ctrl.ref_ok <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        check("holdover", state, 3'h2);
        rd(`ADR_EVENT, 32'h0C, 32'h0C, "hold ev");
        // counter writes ignored when gated or in soft reset
        @(posedge mclk);
        gated <= 1'b1;
        wr(`ADR_LOLCNT, 32'h5);
        rd(`ADR_LOLCNT, 32'hFFFFFFFF, 32'h2, "gated wr");
        @(posedge mclk);
        gated <= 1'b0;
        srst  <= 1'b1;
        wr(`ADR_LOLCNT, 32'h5);
        rd(`ADR_STATUS, 32'hFFFFFFFF, 32'h0, "srst sts");
        rd(`ADR_EVENT, 32'hFFFFFFFF, 32'h0, "srst ev");
        @(posedge mclk);
        srst <= 1'b0;
        rd(`ADR_LOLCNT, 32'hFFFFFFFF, 32'h0, "srst wr");
        rd(`ADR_DELAY, 32'hFFFFFFFF, 32'hA5, "delay kept");
        // write-frequency mode forced from the loop side
        @(posedge mclk);
        ctrl.wr_freq <= 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        check("wr freq", state, 3'h3);
        print_verdict();
    end
endmodule : test_pll_status_event_regs
